// [design/dsu_debug_serial_uart.sv]
// Debug serial port: register file, baud generator, transmitter and receiver.
//
// The strobed register port was decided locally.
`timescale 1ns/1ps

module dsu_debug_serial_uart #(
   parameter int ADDR_W = 32
) (
   // Clock and reset.
   input  wire logic              clk,
   input  wire logic              srst,
   // Register port.
   input  wire logic [ADDR_W-1:0] regAddr,
   input  wire logic [15:0]       regWdata,
   input  wire logic              regWrite,
   input  wire logic              regRead,
   output      logic [15:0]       regRdata,
   // Serial pins.
   input  wire logic              serialRxPin,
   input  wire logic              clearToSendInN,
   output      logic              serialTxPin,
   output      logic              requestToSendOutN
);

   function automatic logic [15:0] divisorOf(input logic [2:0] sel);
      int unsigned rate;
      rate = dsu_pkg::RATE_BPS[sel];
      divisorOf = 16'((dsu_pkg::CLK_HZ + (dsu_pkg::OVERSAMPLE * rate) / 2)
                      / (dsu_pkg::OVERSAMPLE * rate));
   endfunction : divisorOf

   function automatic logic parityOf(input logic [8:0] data, input logic [3:0] nBits,
                                     input logic [1:0] mode);
      logic p;
      p = 1'b0;
      for (int i = 0; i < 9; i++) begin
         if (i < int'(nBits)) begin
            p = p ^ data[i];
         end
      end
      unique case (mode)
         dsu_pkg::PAR_EVEN: parityOf = p;
         dsu_pkg::PAR_ODD:  parityOf = ~p;
         dsu_pkg::PAR_ZERO: parityOf = 1'b0;
         dsu_pkg::PAR_NONE: parityOf = 1'b0;
      endcase
   endfunction : parityOf

   function automatic logic [12:0] frameOf(input logic [8:0] data, input logic [3:0] nBits,
                                           input logic [1:0] mode);
      logic [12:0] f;
      f = 13'h1FFF;
      f[0] = 1'b0;
      for (int i = 0; i < 9; i++) begin
         if (i < int'(nBits)) begin
            f[i+1] = data[i];
         end
      end
      if (mode != dsu_pkg::PAR_NONE) begin
         f[nBits+4'h1] = parityOf(data, nBits, mode);
      end
      frameOf = f;
   endfunction : frameOf

   // Registers.
   logic [15:0]               modeFirst_ff;
   logic [15:0]               modeSecond_ff;
   logic [8:0]                txData_ff;
   logic [7:0]                rateSel_ff;
   logic                      softRst_ff;
   logic [dsu_pkg::FLAG_W-1:0] flags_ff;
   logic [15:0]               rdata_ff;
   logic [15:0]               baudCnt_ff;
   logic                      tick_ff;
   logic [2:0]                rxSync_ff;
   logic [2:0]                ctsSync_ff;
   logic                      rxFilt_ff;
   logic                      ctsFilt_ff;
   logic                      rxPrev_ff;
   logic                      txBusy_ff;
   logic [12:0]               txShift_ff;
   logic [3:0]                txLeft_ff;
   logic [3:0]                txSub_ff;
   logic                      txPin_ff;
   dsu_pkg::dsu_rx_state_t    rxState_ff;
   logic [3:0]                rxSub_ff;
   logic [3:0]                rxIdx_ff;
   logic [10:0]               rxShift_ff;
   logic [8:0]                rxBuf_ff;
   logic                      rxUnread_ff;
   logic [2:0]                rxErr_ff;

   // Decode.
   wire unitRst   = srst | softRst_ff;
   wire wrModeA   = regWrite && (regAddr == ADDR_W'(dsu_pkg::ADDR_MODE_FIRST));
   wire wrModeB   = regWrite && (regAddr == ADDR_W'(dsu_pkg::ADDR_MODE_SECOND));
   wire wrTxExt   = regWrite && (regAddr == ADDR_W'(dsu_pkg::ADDR_TX_EXT));
   wire wrTxPlain = regWrite && (regAddr == ADDR_W'(dsu_pkg::ADDR_TX_PLAIN));
   wire wrFlags   = regWrite && (regAddr == ADDR_W'(dsu_pkg::ADDR_INT_FLAGS));
   wire wrRate    = regWrite && (regAddr == ADDR_W'(dsu_pkg::ADDR_RATE_SEL));
   wire wrSoftRst = regWrite && (regAddr == ADDR_W'(dsu_pkg::ADDR_SOFT_RESET));
   wire rdRxBuf   = regRead && ((regAddr == ADDR_W'(dsu_pkg::ADDR_RX_EXT)) ||
                                (regAddr == ADDR_W'(dsu_pkg::ADDR_RX_PLAIN)));
   wire txStart   = wrTxExt | wrTxPlain;
   wire rxEnable  = modeFirst_ff[dsu_pkg::RX_ENABLE_BIT];
   wire rateOn    = rateSel_ff[dsu_pkg::RATE_ENABLE_BIT];
   wire [1:0] parMode = modeFirst_ff[dsu_pkg::PARITY_MSB:dsu_pkg::PARITY_LSB];
   wire parOn     = parMode != dsu_pkg::PAR_NONE;
   wire [3:0] nData = modeSecond_ff[dsu_pkg::EXT_BIT] ? 4'h9 :
                      (modeFirst_ff[dsu_pkg::CHAR8_BIT] ? 4'h8 : 4'h7);
   wire [3:0] txBits = 4'h2 + nData + {3'h0, parOn} + {3'h0, modeFirst_ff[dsu_pkg::STOP2_BIT]};
   wire [3:0] rxLast = nData + {3'h0, parOn};
   wire [15:0] divisor = divisorOf(rateSel_ff[dsu_pkg::RATE_SEL_MSB:0]);
   wire [8:0] txLoad = wrTxExt ? regWdata[8:0] : {txData_ff[8], regWdata[7:0]};
   wire [8:0] dataMask = 9'((10'h1 << nData) - 10'h1);

   // Receive and transmit completion decode, and clear-to-send change.
   wire rxSampleBit = (rxState_ff == dsu_pkg::RX_DATA) && tick_ff &&
                      (rxSub_ff == dsu_pkg::BIT_TICKS);
   wire rxDone    = rxEnable && rxSampleBit && (rxIdx_ff == rxLast);
   wire [10:0] rxFrame = rxShift_ff | (11'h0);
   wire [8:0] rxChar = rxFrame[8:0] & dataMask;
   wire rxParBit  = rxFrame[nData];
   wire parityErr = parOn && (rxParBit != parityOf(rxChar, nData, parMode));
   wire framingErr = ~rxFilt_ff;
   wire [2:0] newErr = {parityErr, framingErr, rxUnread_ff & ~rdRxBuf};
   wire txDone = txBusy_ff && tick_ff && (txSub_ff == dsu_pkg::BIT_TICKS) &&
                 (txLeft_ff == 4'h1);
   wire ctsChange = ctsFilt_ff != (ctsSync_ff[2] ? 1'b1 : 1'b0) && (ctsSync_ff[1] == ctsSync_ff[2]);

   // Flag set vector; a set in the same cycle as its clear wins.
   wire [dsu_pkg::FLAG_W-1:0] flagSet = {ctsChange,
                                          rxDone && (newErr != 3'h0),
                                          rxDone,
                                          txDone};
   wire [dsu_pkg::FLAG_W-1:0] flagClr = wrFlags ? regWdata[dsu_pkg::FLAG_W-1:0] : 4'h0;
   wire [dsu_pkg::FLAG_W-1:0] nxt_flags = (flags_ff & ~flagClr) | flagSet;

   // Read multiplexer; unmapped addresses read as zero.
   logic [15:0] nxt_rdata;
   always_comb begin
      nxt_rdata = 16'h0000;
      unique case (1'b1)
         regAddr == ADDR_W'(dsu_pkg::ADDR_MODE_FIRST):  nxt_rdata = modeFirst_ff;
         regAddr == ADDR_W'(dsu_pkg::ADDR_MODE_SECOND): nxt_rdata = modeSecond_ff;
         regAddr == ADDR_W'(dsu_pkg::ADDR_RX_EXT):      nxt_rdata = {7'h00, rxBuf_ff};
         regAddr == ADDR_W'(dsu_pkg::ADDR_RX_PLAIN):    nxt_rdata = {8'h00, rxBuf_ff[7:0]};
         regAddr == ADDR_W'(dsu_pkg::ADDR_TX_EXT):      nxt_rdata = {7'h00, txData_ff};
         regAddr == ADDR_W'(dsu_pkg::ADDR_TX_PLAIN):    nxt_rdata = {8'h00, txData_ff[7:0]};
         regAddr == ADDR_W'(dsu_pkg::ADDR_RX_STATUS):   nxt_rdata = {8'h00, txBusy_ff, 4'h0,
                                                                     rxErr_ff};
         regAddr == ADDR_W'(dsu_pkg::ADDR_INT_FLAGS):   nxt_rdata = {12'h000, flags_ff};
         regAddr == ADDR_W'(dsu_pkg::ADDR_RATE_SEL):    nxt_rdata = {8'h00, rateSel_ff};
         regAddr == ADDR_W'(dsu_pkg::ADDR_LINE_STATE):  nxt_rdata = {14'h0000, rxFilt_ff,
                                                                     ctsFilt_ff};
         default:                                       nxt_rdata = 16'h0000;
      endcase
   end

   // Register file. The soft reset bit is a one-cycle pulse that resets the whole port except the read data register.
   always_ff @(posedge clk) begin
      if (unitRst) begin
         modeFirst_ff  <= dsu_pkg::REG_RESET;
         modeSecond_ff <= dsu_pkg::REG_RESET;
         txData_ff     <= dsu_pkg::TX_DATA_RESET;
         rateSel_ff    <= 8'h00;
         flags_ff      <= 4'h0;
      end else begin
         if (wrModeA) begin
            modeFirst_ff <= regWdata;
         end
         if (wrModeB) begin
            modeSecond_ff <= regWdata;
         end
         if (txStart) begin
            txData_ff <= txLoad;
         end
         if (wrRate) begin
            rateSel_ff <= {regWdata[dsu_pkg::RATE_ENABLE_BIT], 4'h0, regWdata[2:0]};
         end
         flags_ff <= nxt_flags;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         softRst_ff <= 1'b0;
         rdata_ff   <= 16'h0000;
      end else begin
         softRst_ff <= wrSoftRst && regWdata[dsu_pkg::SOFT_RESET_BIT];
         rdata_ff   <= regRead ? nxt_rdata : 16'h0000;
      end
   end

   // Baud generator: one tick per sixteenth of a bit, idle while disabled.
   always_ff @(posedge clk) begin
      if (unitRst || !rateOn) begin
         baudCnt_ff <= 16'h0000;
         tick_ff    <= 1'b0;
      end else begin
         tick_ff    <= (baudCnt_ff == divisor - 16'h1);
         baudCnt_ff <= (baudCnt_ff >= divisor - 16'h1) ? 16'h0000 : baudCnt_ff + 16'h1;
      end
   end

   // Pin synchronisers; a level is taken once the second and third stages agree.
   always_ff @(posedge clk) begin
      if (unitRst) begin
         rxSync_ff  <= 3'h7;
         ctsSync_ff <= 3'h7;
         rxFilt_ff  <= 1'b1;
         ctsFilt_ff <= 1'b1;
         rxPrev_ff  <= 1'b1;
      end else begin
         rxSync_ff  <= {rxSync_ff[1:0], serialRxPin};
         ctsSync_ff <= {ctsSync_ff[1:0], clearToSendInN};
         rxPrev_ff  <= rxFilt_ff;
         if (rxSync_ff[1] == rxSync_ff[2]) begin
            rxFilt_ff <= rxSync_ff[2];
         end
         if (ctsSync_ff[1] == ctsSync_ff[2]) begin
            ctsFilt_ff <= ctsSync_ff[2];
         end
      end
   end

   // Transmitter. A write while busy restarts the frame; software is expected not to.
   always_ff @(posedge clk) begin
      if (unitRst) begin
         txBusy_ff  <= 1'b0;
         txShift_ff <= 13'h1FFF;
         txLeft_ff  <= 4'h0;
         txSub_ff   <= 4'h0;
         txPin_ff   <= 1'b1;
      end else if (txStart) begin
         txBusy_ff  <= 1'b1;
         txShift_ff <= frameOf(txLoad, nData, parMode);
         txLeft_ff  <= txBits;
         txSub_ff   <= 4'h0;
         txPin_ff   <= 1'b0;
      end else if (txBusy_ff && tick_ff) begin
         txSub_ff <= txSub_ff + 4'h1;
         if (txSub_ff == dsu_pkg::BIT_TICKS) begin
            txShift_ff <= {1'b1, txShift_ff[12:1]};
            txLeft_ff  <= txLeft_ff - 4'h1;
            txPin_ff   <= (txLeft_ff == 4'h1) ? 1'b1 : txShift_ff[1];
            if (txLeft_ff == 4'h1) begin
               txBusy_ff <= 1'b0;
            end
         end
      end
   end

   // Receiver.
   always_ff @(posedge clk) begin
      if (unitRst || !rxEnable) begin
         rxState_ff <= dsu_pkg::RX_IDLE;
         rxSub_ff   <= 4'h0;
         rxIdx_ff   <= 4'h0;
      end else begin
         unique case (rxState_ff)
            dsu_pkg::RX_IDLE: begin
               rxSub_ff <= 4'h0;
               if (rxPrev_ff && !rxFilt_ff) begin
                  rxState_ff <= dsu_pkg::RX_START;
               end
            end
            dsu_pkg::RX_START: begin
               if (tick_ff) begin
                  rxSub_ff <= rxSub_ff + 4'h1;
                  if (rxSub_ff == dsu_pkg::HALF_BIT_TICKS) begin
                     rxSub_ff   <= 4'h0;
                     rxIdx_ff   <= 4'h0;
                     rxState_ff <= rxFilt_ff ? dsu_pkg::RX_IDLE : dsu_pkg::RX_DATA;
                  end
               end
            end
            dsu_pkg::RX_DATA: begin
               if (tick_ff) begin
                  rxSub_ff <= rxSub_ff + 4'h1;
               end
               if (rxSampleBit) begin
                  rxIdx_ff <= rxIdx_ff + 4'h1;
                  if (rxIdx_ff == rxLast) begin
                     rxState_ff <= dsu_pkg::RX_IDLE;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (unitRst) begin
         rxShift_ff <= 11'h000;
      end else if (rxSampleBit && rxEnable) begin
         rxShift_ff[rxIdx_ff] <= rxFilt_ff;
      end
   end

   // Receive buffer and error status; a new character takes precedence over a read.
   always_ff @(posedge clk) begin
      if (unitRst) begin
         rxBuf_ff    <= 9'h000;
         rxUnread_ff <= 1'b0;
         rxErr_ff    <= 3'h0;
      end else if (rxDone) begin
         rxBuf_ff    <= rxChar;
         rxUnread_ff <= 1'b1;
         rxErr_ff    <= newErr;
      end else if (rdRxBuf) begin
         rxUnread_ff <= 1'b0;
         rxErr_ff    <= 3'h0;
      end
   end

   assign regRdata          = rdata_ff;
   assign serialTxPin       = txPin_ff;
   assign requestToSendOutN = ~modeFirst_ff[dsu_pkg::RX_ENABLE_BIT];

endmodule : dsu_debug_serial_uart

// [design/dsu_pkg.sv]
// Shared constants and types for the debug serial port.
package dsu_pkg;

   // Register offsets on the plain register port.
   localparam logic [31:0] ADDR_MODE_FIRST  = 32'h0B0001A0;
   localparam logic [31:0] ADDR_MODE_SECOND = 32'h0B0001A2;
   localparam logic [31:0] ADDR_RX_EXT      = 32'h0B0001A8;
   localparam logic [31:0] ADDR_RX_PLAIN    = 32'h0B0001AA;
   localparam logic [31:0] ADDR_TX_EXT      = 32'h0B0001AC;
   localparam logic [31:0] ADDR_TX_PLAIN    = 32'h0B0001AE;
   localparam logic [31:0] ADDR_RX_STATUS   = 32'h0B0001B0;
   localparam logic [31:0] ADDR_INT_FLAGS   = 32'h0B0001B2;
   localparam logic [31:0] ADDR_RATE_SEL    = 32'h0B0001B6;
   localparam logic [31:0] ADDR_SOFT_RESET  = 32'h0B0001B8;
   localparam logic [31:0] ADDR_LINE_STATE  = 32'h0B0001BA;

   // Interrupt flag positions.
   localparam int FLAG_TX_DONE  = 0;
   localparam int FLAG_RX_DONE  = 1;
   localparam int FLAG_RX_ERR   = 2;
   localparam int FLAG_CTS_CHG  = 3;
   localparam int FLAG_W        = 4;

   // Field positions.
   localparam int RATE_ENABLE_BIT = 7;
   localparam int RATE_SEL_MSB    = 2;
   localparam int SOFT_RESET_BIT  = 0;
   localparam int RX_ENABLE_BIT   = 6;
   localparam int PARITY_MSB      = 3;
   localparam int PARITY_LSB      = 2;
   localparam int CHAR8_BIT       = 1;
   localparam int STOP2_BIT       = 0;
   localparam int EXT_BIT         = 0;
   localparam int TX_BUSY_BIT     = 7;
   localparam int PARITY_ERR_BIT  = 2;
   localparam int FRAMING_ERR_BIT = 1;
   localparam int OVERRUN_ERR_BIT = 0;

   // Values after reset.
   localparam logic [8:0]  TX_DATA_RESET = 9'h1FF;
   localparam logic [15:0] REG_RESET     = 16'h0000;

   // Parity modes held in the first mode register.
   localparam logic [1:0] PAR_NONE = 2'h0;
   localparam logic [1:0] PAR_ZERO = 2'h1;
   localparam logic [1:0] PAR_ODD  = 2'h2;
   localparam logic [1:0] PAR_EVEN = 2'h3;

   // Timing.
   localparam int unsigned CLK_HZ         = 20_000_000;
   localparam int unsigned OVERSAMPLE     = 16;
   localparam logic [3:0]  BIT_TICKS      = 4'hF;
   localparam logic [3:0]  HALF_BIT_TICKS = 4'h7;
   localparam int unsigned RATE_BPS [8] = '{1200, 2400, 4800, 9600,
                                            19200, 38400, 57600, 115200};

   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} dsu_rx_state_t;

endpackage : dsu_pkg

// [test/dsu_debug_serial_uart_assertions.sv]
// Port-level assertions for the debug serial port.
`timescale 1ns/1ps
module dsu_debug_serial_uart_checker #(
   parameter int ADDR_W = 32
) (
   // Clock and reset.
   input wire logic              clk,
   input wire logic              srst,
   // Register port.
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [15:0]       regWdata,
   input wire logic              regWrite,
   input wire logic              regRead,
   input wire logic [15:0]       regRdata,
   // Serial pins.
   input wire logic              serialRxPin,
   input wire logic              clearToSendInN,
   input wire logic              serialTxPin,
   input wire logic              requestToSendOutN
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   sequence seqTxWr;
      regWrite && (regAddr == dsu_pkg::ADDR_TX_PLAIN || regAddr == dsu_pkg::ADDR_TX_EXT);
   endsequence
   sequence seqRd(a);
      regRead && regAddr == a;
   endsequence

   AST_RDATA_IDLE: assert property (!regRead |=> regRdata == 16'h0000)
      else $error("read data not zero outside a read answer");
   AST_FLAG_RSV: assert property (seqRd(dsu_pkg::ADDR_INT_FLAGS) |=> regRdata[15:4] == 12'h000)
      else $error("flag register upper bits not zero");
   AST_RATE_RSV: assert property (seqRd(dsu_pkg::ADDR_RATE_SEL) |=> regRdata[15:8] == 8'h00)
      else $error("rate register upper bits not zero");
   AST_SRST_READ: assert property (seqRd(dsu_pkg::ADDR_SOFT_RESET) |=> regRdata == 16'h0000)
      else $error("soft reset register not reading zero");
   AST_RTS: assert property (regWrite && regAddr == dsu_pkg::ADDR_MODE_FIRST |=>
      requestToSendOutN == !$past(regWdata[6])) else $error("request-to-send level wrong");
   AST_TX_START: assert property (seqTxWr |=> (!serialTxPin) [*8])
      else $error("start bit not driven after transmit write");
   AST_IDLE_AFTER_RST: assert property ($fell(srst) |-> serialTxPin && requestToSendOutN)
      else $error("pins not idle after reset");
   AST_BUSY_SET: assert property (seqTxWr ##[1:2] seqRd(dsu_pkg::ADDR_RX_STATUS) |=> regRdata[7])
      else $error("busy not set after transmit write");
endmodule : dsu_debug_serial_uart_checker

// [test/dsu_remote_terminal.sv]
// Remote serial terminal model: frame sender, frame catcher and flow-control pin.
`timescale 1ns/1ps
module dsu_remote_terminal #(
   parameter int BIT_CLKS = 176
) (
   // Clock.
   input  wire logic clk,
   // Serial pins.
   input  wire logic serialTxPin,
   output      logic serialRxPin,
   output      logic clearToSendInN
);
   logic [7:0] caughtByte;
   logic [7:0] shiftByte;

   initial begin
      serialRxPin    = 1'b1;
      clearToSendInN = 1'b1;
      caughtByte     = 8'h00;
      shiftByte      = 8'h00;
   end

   // Start, eight bits LSB first, one stop; a bad stop is driven low.
   task automatic send(input logic [7:0] data, input logic badStop);
      logic [9:0] frm;
      frm = {!badStop, data, 1'b0};
      for (int i = 0; i < 10; i++) begin
         serialRxPin <= frm[i];
         repeat (BIT_CLKS) @(posedge clk);
      end
      serialRxPin <= 1'b1;
   endtask : send

   // A low pulse too short to be a start bit, then idle for one bit time.
   task automatic glitch(input int n);
      serialRxPin <= 1'b0;
      repeat (n) @(posedge clk);
      serialRxPin <= 1'b1;
      repeat (BIT_CLKS) @(posedge clk);
   endtask : glitch

   // High means this side is ready to take data.
   task automatic setCts(input logic v);
      clearToSendInN <= v;
   endtask : setCts

   // Samples mid-bit; the first tick's phase may shorten the start bit by one tick.
   always @(negedge serialTxPin) begin
      repeat (BIT_CLKS / 2) @(posedge clk);
      if (!serialTxPin) begin
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLKS) @(posedge clk);
            shiftByte[i] = serialTxPin;
         end
         caughtByte = shiftByte;
      end
   end
endmodule : dsu_remote_terminal

// [test/tb_debug_serial_uart.sv]
// Testbench for the debug serial port.
`timescale 1ns/1ps
module tb_debug_serial_uart;
   localparam int ADDR_W = 32;
   logic              clk = 1'b0;
   logic              srst = 1'b1;
   logic [31:0]       regAddr = 32'h00000000;
   logic [15:0]       regWdata = 16'h0000;
   logic              regWrite = 1'b0;
   logic              regRead = 1'b0;
   logic [15:0]       regRdata;
   logic              serialRxPin;
   logic              clearToSendInN;
   logic              serialTxPin;
   logic              requestToSendOutN;
   int                errorCnt = 0;
   int                checks = 0;

   always #25 clk = ~clk;

   dsu_debug_serial_uart #(.ADDR_W(ADDR_W)) u_dsu_debug_serial_uart (
      .clk(clk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
      .regRead(regRead), .regRdata(regRdata), .serialRxPin(serialRxPin),
      .clearToSendInN(clearToSendInN), .serialTxPin(serialTxPin),
      .requestToSendOutN(requestToSendOutN));

   // Rate 7 gives 11 clocks a tick, 16 ticks a bit.
   dsu_remote_terminal #(.BIT_CLKS(176)) u_rem (
      .clk(clk), .serialTxPin(serialTxPin), .serialRxPin(serialRxPin),
      .clearToSendInN(clearToSendInN));

   task automatic summarize();
      if (errorCnt == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : summarize

   task automatic wr(input logic [31:0] a, input logic [15:0] d);
      @(posedge clk);
      regAddr  <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
      // Registers written at this edge settle before a caller looks at the outputs.
      #1;
   endtask : wr

   task automatic rd(input logic [31:0] a, output logic [15:0] d);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      #1 d = regRdata;
   endtask : rd

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         errorCnt++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic rdChk(input logic [31:0] a, input logic [15:0] exp);
      logic [15:0] d;
      rd(a, d);
      chk(d, exp);
   endtask : rdChk

   task automatic waitFlag(input int b);
      logic [15:0] d;
      for (int n = 0; n < 3000; n++) begin
         rd(dsu_pkg::ADDR_INT_FLAGS, d);
         if (d[b] === 1'b1) return;
      end
      errorCnt++;
      $display("BAD %0t flag wait timed out", $time);
      summarize();
   endtask : waitFlag

   initial begin
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      rdChk(dsu_pkg::ADDR_INT_FLAGS, 16'h0000);
      rdChk(dsu_pkg::ADDR_RATE_SEL, 16'h0000);
      rdChk(dsu_pkg::ADDR_SOFT_RESET, 16'h0000);
      rdChk(32'h0B0001C0, 16'h0000);
      chk({15'h0000, requestToSendOutN}, 16'h0001);
      u_rem.setCts(1'b0);
      repeat (10) @(posedge clk);
      rdChk(dsu_pkg::ADDR_INT_FLAGS, 16'h0008);
      wr(dsu_pkg::ADDR_INT_FLAGS, 16'h0000);
      rdChk(dsu_pkg::ADDR_INT_FLAGS, 16'h0008);
      wr(dsu_pkg::ADDR_INT_FLAGS, 16'h0008);
      rdChk(dsu_pkg::ADDR_INT_FLAGS, 16'h0000);
      // The last setting left is rate 7, enabled; nothing is in flight while it changes.
      for (int i = 0; i < 8; i++) begin
         wr(dsu_pkg::ADDR_RATE_SEL, 16'h0080 | 16'(i));
         rdChk(dsu_pkg::ADDR_RATE_SEL, 16'h0080 | 16'(i));
      end
      wr(dsu_pkg::ADDR_MODE_FIRST, 16'h0042);
      chk({15'h0000, requestToSendOutN}, 16'h0000);
      // The far side shows it is ready with clear-to-send high before data goes out.
      u_rem.setCts(1'b1);
      repeat (10) @(posedge clk);
      wr(dsu_pkg::ADDR_INT_FLAGS, 16'h0008);
      rdChk(dsu_pkg::ADDR_LINE_STATE, 16'h0003);
      wr(dsu_pkg::ADDR_TX_PLAIN, 16'h00A5);
      rdChk(dsu_pkg::ADDR_RX_STATUS, 16'h0080);
      waitFlag(0);
      chk({8'h00, u_rem.caughtByte}, 16'h00A5);
      rdChk(dsu_pkg::ADDR_RX_STATUS, 16'h0000);
      rdChk(dsu_pkg::ADDR_INT_FLAGS, 16'h0001);
      chk({15'h0000, serialTxPin}, 16'h0001);
      wr(dsu_pkg::ADDR_INT_FLAGS, 16'h0001);
      u_rem.send(8'h3C, 1'b0);
      waitFlag(1);
      rdChk(dsu_pkg::ADDR_INT_FLAGS, 16'h0002);
      rdChk(dsu_pkg::ADDR_RX_PLAIN, 16'h003C);
      wr(dsu_pkg::ADDR_INT_FLAGS, 16'h000F);
      u_rem.send(8'h11, 1'b0);
      u_rem.send(8'h22, 1'b0);
      waitFlag(2);
      rdChk(dsu_pkg::ADDR_INT_FLAGS, 16'h0006);
      rdChk(dsu_pkg::ADDR_RX_STATUS, 16'h0001);
      rdChk(dsu_pkg::ADDR_RX_PLAIN, 16'h0022);
      rdChk(dsu_pkg::ADDR_RX_STATUS, 16'h0000);
      wr(dsu_pkg::ADDR_INT_FLAGS, 16'h000F);
      u_rem.send(8'h55, 1'b1);
      waitFlag(2);
      rdChk(dsu_pkg::ADDR_RX_STATUS, 16'h0002);
      rdChk(dsu_pkg::ADDR_RX_PLAIN, 16'h0055);
      wr(dsu_pkg::ADDR_INT_FLAGS, 16'h000F);
      u_rem.glitch(44);
      rdChk(dsu_pkg::ADDR_INT_FLAGS, 16'h0000);
      u_rem.send(8'h66, 1'b0);
      waitFlag(1);
      rdChk(dsu_pkg::ADDR_RX_PLAIN, 16'h0066);
      wr(dsu_pkg::ADDR_INT_FLAGS, 16'h000F);
      wr(dsu_pkg::ADDR_MODE_FIRST, 16'h0002);
      chk({15'h0000, requestToSendOutN}, 16'h0001);
      u_rem.send(8'h77, 1'b0);
      rdChk(dsu_pkg::ADDR_INT_FLAGS, 16'h0000);
      rdChk(dsu_pkg::ADDR_RX_PLAIN, 16'h0066);
      wr(dsu_pkg::ADDR_MODE_FIRST, 16'h0042);
      fork
         u_rem.send(8'h99, 1'b0);
         begin
            repeat (800) @(posedge clk);
            wr(dsu_pkg::ADDR_MODE_FIRST, 16'h0002);
         end
      join
      rdChk(dsu_pkg::ADDR_INT_FLAGS, 16'h0000);
      rdChk(dsu_pkg::ADDR_RX_STATUS, 16'h0000);
      rdChk(dsu_pkg::ADDR_RX_PLAIN, 16'h0066);
      u_rem.setCts(1'b1);
      repeat (10) @(posedge clk);
      wr(dsu_pkg::ADDR_INT_FLAGS, 16'h000F);
      wr(dsu_pkg::ADDR_TX_EXT, 16'h005A);
      // Let the start bit stand a few cycles so the reset cuts a frame in flight.
      repeat (10) @(posedge clk);
      wr(dsu_pkg::ADDR_SOFT_RESET, 16'h0001);
      rdChk(dsu_pkg::ADDR_RATE_SEL, 16'h0000);
      rdChk(dsu_pkg::ADDR_SOFT_RESET, 16'h0000);
      repeat (2000) @(posedge clk);
      rdChk(dsu_pkg::ADDR_INT_FLAGS, 16'h0000);
      chk({15'h0000, serialTxPin}, 16'h0001);
      summarize();
   end
endmodule : tb_debug_serial_uart

bind dsu_debug_serial_uart dsu_debug_serial_uart_checker #(.ADDR_W(ADDR_W)) u_chk (
   .clk(clk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
   .regRead(regRead), .regRdata(regRdata), .serialRxPin(serialRxPin),
   .clearToSendInN(clearToSendInN), .serialTxPin(serialTxPin),
   .requestToSendOutN(requestToSendOutN));
